//--- logic/pit_pkg.sv
// Constants and register map of the prescaled interval timer
// Overview of operation
// - A 16-bit down-counter decrements by one on every prescaled tick while it is above one.
// - An 8-bit prescale register holds n minus one; zero means every cycle.
// - When a tick finds the down-counter at one (or zero) a timer interrupt is raised.
// - On that tick the counter reloads from the 16-bit period register instead of stepping to zero.
package pit_pkg;
   localparam int PIT_COUNT_W = 16;
   localparam int PIT_SCALE_W = 8;
   localparam logic [7:0] PIT_OFS_COUNT = 8'h00;
   localparam logic [7:0] PIT_OFS_SCALE = 8'h04;
   localparam logic [7:0] PIT_OFS_PERIOD = 8'h08;
   localparam logic [7:0] PIT_OFS_CTRL = 8'h0c;
   localparam logic [7:0] PIT_OFS_STATUS = 8'h10;
   localparam logic [7:0] PIT_OFS_CLEAR = 8'h14;
   localparam logic [7:0] PIT_OFS_IRQ_EN = 8'h18;
   localparam logic [15:0] PIT_COUNT_RST = 16'h0000;
   localparam logic [7:0] PIT_SCALE_RST = 8'h00;
   localparam logic [15:0] PIT_PERIOD_RST = 16'h0000;
   localparam int PIT_CTRL_EN_BIT = 0;
   localparam int PIT_STAT_ZERO_BIT = 0;
endpackage

//--- logic/pit_prescaler.sv
// Prescaler that issues one tick every prescale+1 cycles
`timescale 1ns/10ps
module pit_prescaler
   import pit_pkg::*;
#(
   parameter int SCALE_W = PIT_SCALE_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [SCALE_W-1:0] scale,
   output logic tick
);
   logic [SCALE_W-1:0] cnt_q;
   wire at_end = (cnt_q == '0);
   assign tick = run && at_end;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!run || at_end) begin
         cnt_q <= scale;
      end else begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

//--- logic/pit_timer.sv
// APB interval timer top: registers, down-counter and interrupt
`timescale 1ns/10ps
module pit_timer
   import pit_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   logic [15:0] timer_down_count_q;
   logic [7:0] timer_prescale_q;
   logic [15:0] timer_reload_period_q;
   logic enable_q;
   logic zero_stat_q;
   logic zero_en_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic tick;

   // One wait state: setup, access, then pready
   wire acc = psel && penable && !pready_q;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_count = (paddr == PIT_OFS_COUNT);
   wire hit_scale = (paddr == PIT_OFS_SCALE);
   wire hit_period = (paddr == PIT_OFS_PERIOD);
   wire hit_ctrl = (paddr == PIT_OFS_CTRL);
   wire hit_stat = (paddr == PIT_OFS_STATUS);
   wire hit_clr = (paddr == PIT_OFS_CLEAR);
   wire hit_en = (paddr == PIT_OFS_IRQ_EN);
   wire mapped = hit_count | hit_scale | hit_period | hit_ctrl | hit_stat | hit_clr | hit_en;
   wire at_zero = enable_q && tick && (timer_down_count_q == 16'h0001 || timer_down_count_q == 16'h0000);
   wire dec_step = enable_q && tick && !at_zero;
   wire clr_zero = wr && hit_clr && pwdata[PIT_STAT_ZERO_BIT];
   wire irq_d = (zero_stat_q || at_zero) && zero_en_q;
   wire [31:0] rd_mux =
      hit_count ? {16'h0000, timer_down_count_q} :
      hit_scale ? {24'h000000, timer_prescale_q} :
      hit_period ? {16'h0000, timer_reload_period_q} :
      hit_ctrl ? {31'h00000000, enable_q} :
      hit_stat ? {31'h00000000, zero_stat_q} :
      hit_en ? {31'h00000000, zero_en_q} : 32'h00000000;

   pit_prescaler #(.SCALE_W(PIT_SCALE_W)) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .run(enable_q),
      .scale(timer_prescale_q),
      .tick(tick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
         prdata_q <= rd ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_prescale_q <= PIT_SCALE_RST;
         timer_reload_period_q <= PIT_PERIOD_RST;
         enable_q <= 1'b0;
         zero_en_q <= 1'b0;
      end else if (wr) begin
         if (hit_scale) timer_prescale_q <= pwdata[7:0];
         if (hit_period) timer_reload_period_q <= pwdata[15:0];
         if (hit_ctrl) enable_q <= pwdata[PIT_CTRL_EN_BIT];
         if (hit_en) zero_en_q <= pwdata[PIT_STAT_ZERO_BIT];
      end
   end

   // Counter: software write wins over the tick; zero reloads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_down_count_q <= PIT_COUNT_RST;
      end else if (wr && hit_count) begin
         timer_down_count_q <= pwdata[15:0];
      end else if (at_zero) begin
         timer_down_count_q <= timer_reload_period_q;
      end else if (dec_step) begin
         timer_down_count_q <= timer_down_count_q - 16'h0001;
      end
   end

   // Sticky event, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_stat_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         zero_stat_q <= at_zero || (zero_stat_q && !clr_zero);
         irq_q <= irq_d && !(clr_zero && !at_zero);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   a_zero_sets_stat: assert property (@(posedge pclk) disable iff (!presetn)
      at_zero |=> zero_stat_q)
      else $error("zero event not latched");

   a_reload_on_zero: assert property (@(posedge pclk) disable iff (!presetn)
      at_zero && !(wr && hit_count) |=> timer_down_count_q == $past(timer_reload_period_q))
      else $error("counter not reloaded");

   a_decrement_one: assert property (@(posedge pclk) disable iff (!presetn)
      dec_step && !(wr && hit_count) |=> timer_down_count_q == $past(timer_down_count_q) - 16'h0001)
      else $error("bad decrement");

   a_hold_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
      !tick && !(wr && hit_count) |=> $stable(timer_down_count_q))
      else $error("count moved without tick");

   a_scale_zero_tick: assert property (@(posedge pclk) disable iff (!presetn)
      enable_q && timer_prescale_q == 8'h00 && $past(enable_q) && $past(timer_prescale_q) == 8'h00 |-> tick)
      else $error("scale zero must tick each cycle");

   a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      tick && timer_prescale_q == 8'h01 && enable_q |=> !tick)
      else $error("tick too early");

   a_tick_repeat: assert property (@(posedge pclk) disable iff (!presetn)
      tick && timer_prescale_q == 8'h01 && enable_q ##1 enable_q && timer_prescale_q == 8'h01 |=> tick)
      else $error("tick not repeated");

   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      at_zero && zero_en_q |=> irq)
      else $error("irq missing");

   // Bus answer is a single-cycle pulse
   a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held too long");

   // One wait state after the first access edge
   a_ready_after_acc: assert property (@(posedge pclk) disable iff (!presetn)
      acc |=> pready)
      else $error("pready missing");

   // Error flag only with the answer
   a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");

   // Read data is zero outside the answer cycle
   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h00000000)
      else $error("read data not zero when idle");

   // Unmapped writes change nothing
   a_unmapped_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      wr && !mapped |=> $stable(timer_prescale_q) && $stable(timer_reload_period_q) && $stable(enable_q))
      else $error("unmapped write took effect");

   // Prescale write lands
   a_scale_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_scale |=> timer_prescale_q == $past(pwdata[7:0]))
      else $error("prescale write lost");

   // Period write lands
   a_period_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_period |=> timer_reload_period_q == $past(pwdata[15:0]))
      else $error("period write lost");

   // Counter write beats the tick
   a_count_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_count |=> timer_down_count_q == $past(pwdata[15:0]))
      else $error("count write lost");

   // Enable write lands
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl |=> enable_q == $past(pwdata[PIT_CTRL_EN_BIT]))
      else $error("enable write lost");

   // Stopped timer never ticks
   a_no_tick_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !enable_q |-> !tick)
      else $error("tick while disabled");

   // Plain decrements never cross the event point
   a_dec_above_one: assert property (@(posedge pclk) disable iff (!presetn)
      dec_step |-> timer_down_count_q > 16'h0001)
      else $error("decrement at event point");

   // Status stays set until cleared
   a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      zero_stat_q && !clr_zero |=> zero_stat_q)
      else $error("status lost without clear");

   // Clear without a new event drops status and line
   a_clear_drops: assert property (@(posedge pclk) disable iff (!presetn)
      clr_zero && !at_zero |=> !zero_stat_q && !irq)
      else $error("clear ignored");

   // Masked event keeps the line low
   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      !zero_en_q |=> !irq)
      else $error("irq while masked");

   // Line high only with status set
   a_irq_needs_stat: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> zero_stat_q)
      else $error("irq without status");

   // Count read returns the counter
   a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
      rd && hit_count |=> prdata == {16'h0000, $past(timer_down_count_q)})
      else $error("count read wrong");
endmodule

//--- sim/prescaled_interval_timer_test.sv
// Self-checking bench for the prescaled interval timer
`timescale 1ns/10ps
module prescaled_interval_timer_test;
   import pit_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, err_q;
   int errors = 0, tests_run = 0, seed = 32'he703, s, p, n;
   pit_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   always #12.5 pclk = ~pclk;
   task end_of_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at pready where it is settled, then release after the edge that samples it
      k = 0;
      @(negedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         @(negedge pclk);
         k++;
      end
      if (k >= 20) begin
         errors++;
         end_of_test;
      end
      rd = prdata;
      err_q = pslverr;
      @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Cycles until irq rises, bounded
   task wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 5000) begin
         errors++;
         end_of_test;
      end
   endtask
   function logic in_range(int v, int lo, int hi);
      return v >= lo && v <= hi;
   endfunction
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PIT_OFS_COUNT, 32'h0); chk(rd, {16'h0, PIT_COUNT_RST});
      apb(1'b0, PIT_OFS_SCALE, 32'h0); chk(rd, {24'h0, PIT_SCALE_RST});
      apb(1'b0, PIT_OFS_PERIOD, 32'h0); chk(rd, {16'h0, PIT_PERIOD_RST});
      apb(1'b0, 8'h1c, 32'h0); chk({31'h0, err_q}, 32'h1);
      repeat (3) begin
         s = 8 + ($unsigned($random(seed)) % 8);
         p = 2 + ($unsigned($random(seed)) % 4);
         apb(1'b1, PIT_OFS_SCALE, s);
         apb(1'b1, PIT_OFS_PERIOD, p);
         apb(1'b1, PIT_OFS_COUNT, 32'h5);
         apb(1'b1, PIT_OFS_IRQ_EN, 32'h1);
         apb(1'b1, PIT_OFS_CTRL, 32'h1);
         wait_irq;
         chk(in_range(n, 4 * (s + 1), 5 * (s + 1) + 3), 32'h1);
         apb(1'b1, PIT_OFS_CLEAR, 32'h1);
         wait_irq;
         chk(in_range(n, (p - 1) * (s + 1) - 4, p * (s + 1) + 3), 32'h1);
         apb(1'b1, PIT_OFS_CTRL, 32'h0);
         apb(1'b0, PIT_OFS_COUNT, 32'h0); chk(rd, p);
         apb(1'b0, PIT_OFS_STATUS, 32'h0); chk(rd, 32'h1);
         apb(1'b1, PIT_OFS_IRQ_EN, 32'h0);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, PIT_OFS_CLEAR, 32'h1);
         apb(1'b0, PIT_OFS_STATUS, 32'h0); chk(rd, 32'h0);
      end
      // Corner: stored zero ticks every cycle
      apb(1'b1, PIT_OFS_SCALE, 32'h0);
      apb(1'b1, PIT_OFS_PERIOD, 32'h3);
      apb(1'b1, PIT_OFS_COUNT, 32'h3);
      apb(1'b1, PIT_OFS_IRQ_EN, 32'h1);
      apb(1'b1, PIT_OFS_CTRL, 32'h1);
      wait_irq;
      chk(in_range(n, 2, 6), 32'h1);
      end_of_test;
   end
endmodule
